// File: rtl/can_status_map.vh
// register offsets, field positions and sizes for the message object status and tag block
`ifndef CAN_STATUS_MAP_VH
`define CAN_STATUS_MAP_VH
`define ADDR_PAGE 8'hb1
`define ADDR_OBJECT_STATUS 8'hb2
`define ADDR_OBJECT_CONTROL 8'hb3
`define ADDR_ID_TAG_ONE 8'hbc
`define ADDR_ID_TAG_TWO 8'hbd
`define ADDR_ID_TAG_THREE 8'hbe
`define BIT_LENGTH_WARN 7
`define BIT_TX_DONE 6
`define BIT_RX_DONE 5
`define BIT_BIT_ERR 4
`define BIT_STUFF_ERR 3
`define BIT_CRC_ERR 2
`define BIT_FORM_ERR 1
`define BIT_ACK_ERR 0
`define OBJ_COUNT 15
`define OBJ_LAST 4'he
`define OBJ_PRIO_LAST 13
`define OBJ_NONE 4'hf
`define CTRL_EXT_BIT 4
`define CTRL_CONF_TX 2'h1
`define CTRL_CONF_RX 2'h2
`define CTRL_CONF_RXBUF 2'h3
`define STUFF_LIMIT 3'h5
`define ZERO_BYTE 8'h00
`define ZERO_NIBBLE 4'h0
`endif

// File: rtl/obj_memory.v
// small per-object byte memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module obj_memory (
  input wire core_clk,
  input wire writeEn,
  input wire [3:0] writeAddr,
  input wire [7:0] writeData,
  input wire [3:0] readAddr,
  output reg [7:0] readData
);
  reg [7:0] store [0:15];

  // no reset: contents stay undefined until written
  always @(posedge core_clk) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
    readData <= store[readAddr];
  end
endmodule // obj_memory
`default_nettype wire

// File: rtl/lowest_pick.v
// lowest-index picker over the prioritised message objects
`timescale 1ns/10ps
`default_nettype none
`include "can_status_map.vh"
module lowest_pick (
  input wire [14:0] request,
  output reg [3:0] winner
);
  integer i;

  // scan downward so the lowest index is the last to overwrite
  always @* begin
    winner = `OBJ_NONE;
    for (i = `OBJ_PRIO_LAST; i >= 0; i = i - 1) begin
      if (request[i]) begin
        winner = i[3:0];
      end
    end
  end
endmodule // lowest_pick
`default_nettype wire

// File: rtl/can_obj_status.v
// message object status flags and standard identifier tag registers
//
// Overview of operation
// RQ1: received length code differing from programmed length sets the length warning flag.
// RQ2: successful transmission of an enabled object sets transmit complete, bit 6.
// RQ3: among several pending transmit objects, lowest index 0 to 13 goes first.
// RQ4: completed reception on an enabled object sets receive complete, bit 5.
// RQ5: frame matching several receive objects updates lowest index first.
// RQ6: while transmitting, monitored level differing from driven level sets bit error, bit 4.
// RQ7: no bit error for recessive-sent dominant-seen in arbitration, ack, error frame.
// RQ8: more than five equal consecutive stuffed bits set stuff error, bit 3.
// RQ9: receiver CRC mismatch over destuffed start-to-data sets CRC error, bit 2.
// RQ10: illegal bit in CRC delimiter, ack delimiter or end of frame sets form error.
// RQ11: transmitter seeing no dominant ack slot sets ack error, bit 0.
// RQ12: every flag stays set until software clears it, and raises the interrupt.
// RQ13: tag byte one holds identifier bits 10 to 3.
// RQ14: tag byte two holds identifier bits 2 to 0 in bits 7-5.
// RQ15: tag byte three holds no identifier bits.
// RQ16: unused tag bits read any value; software writes them zero.
// RQ17: tag registers are not reset; undefined until written.
// RQ18: extension setting selects 11 or 29 bit identifier; layout for 11 only.
// RQ19: status and tag registers follow the page object number, 0 to 14.
`timescale 1ns/10ps
`default_nettype none
`include "can_status_map.vh"
module can_obj_status (
  input wire core_clk,
  input wire rst_n,
  input wire sfrWr,
  input wire sfrRd,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  output reg [7:0] sfrRdata,
  input wire busReady,
  input wire txDone,
  input wire rxDone,
  input wire [14:0] rxHit,
  input wire [3:0] rxLength,
  input wire txActive,
  input wire txLevel,
  input wire busLevelPin,
  input wire inArbOrAck,
  input wire inErrorFrame,
  input wire bitStrobe,
  input wire stuffedField,
  input wire crcMismatch,
  input wire fixedFieldBad,
  input wire ackSlot,
  output reg canIrq,
  output reg [3:0] txObject,
  output reg txStart,
  output reg [3:0] rxObject
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [3:0] pageObj;
  reg [7:0] flags [0:14];
  reg [7:0] ctrl [0:14];
  reg busSync1;
  reg busSync2;
  reg [2:0] runLen;
  reg prevLevel;
  reg ackSeen;
  reg [3:0] servedTx;
  reg [3:0] servedRx;
  wire [14:0] txPending;
  wire [14:0] rxEnabled;
  wire [3:0] txWinner;
  wire [3:0] rxWinner;
  wire [7:0] tagOneData;
  wire [7:0] tagTwoData;
  wire [14:0] anyFlag;
  reg [7:0] next_event;
  wire [3:0] eventObj;

  // errors in a reception's rxDone cycle belong to the object it lands in, not the one served before
  assign eventObj = txActive ? servedTx : (rxDone ? rxWinner : servedRx);

  // ----------------------------------------
  // bus pin synchroniser
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      busSync1 <= 1'b1;
      busSync2 <= 1'b1;
    end else begin
      busSync1 <= busLevelPin;
      busSync2 <= busSync1;
    end
  end

  // ----------------------------------------
  // object selection
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `OBJ_COUNT; g = g + 1) begin : objSel
      assign txPending[g] = ctrl[g][7:6] == `CTRL_CONF_TX;
      assign rxEnabled[g] = rxHit[g] && ctrl[g][7] == 1'b1;
      assign anyFlag[g] = |flags[g];
    end
  endgenerate

  lowest_pick txPick (
    .request(txPending),
    .winner(txWinner)
  ); // [RQ3]

  lowest_pick rxPick (
    .request(rxEnabled),
    .winner(rxWinner)
  ); // [RQ5]

  always @(posedge core_clk) begin
    if (!rst_n) begin
      txObject <= `OBJ_NONE;
      txStart <= 1'b0;
      rxObject <= `OBJ_NONE;
      servedTx <= `OBJ_NONE;
      servedRx <= `OBJ_NONE;
    end else begin
      txStart <= busReady && txWinner != `OBJ_NONE;
      if (busReady) begin
        txObject <= txWinner; // [RQ3]
        servedTx <= txWinner;
      end
      if (rxDone) begin
        rxObject <= rxWinner; // [RQ5]
        servedRx <= rxWinner;
      end
    end
  end

  // ----------------------------------------
  // error detection on the monitored bus
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      runLen <= 3'h0;
      prevLevel <= 1'b1;
      ackSeen <= 1'b0;
    end else if (bitStrobe) begin
      prevLevel <= busSync2;
      if (!stuffedField || busSync2 != prevLevel) begin
        runLen <= 3'h1;
      end else if (runLen <= `STUFF_LIMIT) begin
        runLen <= runLen + 3'h1;
      end
      if (ackSlot) begin
        ackSeen <= !busSync2;
      end
    end
  end

  // one-cycle events, applied to whichever object is active
  always @* begin
    next_event = `ZERO_BYTE;
    if (txActive && bitStrobe && txLevel != busSync2 &&
        !((inArbOrAck && txLevel) || (inErrorFrame && !busSync2))) begin
      next_event[`BIT_BIT_ERR] = 1'b1; // [RQ6] [RQ7]
    end
    if (bitStrobe && stuffedField && busSync2 == prevLevel && runLen == `STUFF_LIMIT) begin
      next_event[`BIT_STUFF_ERR] = 1'b1; // [RQ8]
    end
    if (rxDone && crcMismatch) begin
      next_event[`BIT_CRC_ERR] = 1'b1; // [RQ9]
    end
    if (fixedFieldBad) begin
      next_event[`BIT_FORM_ERR] = 1'b1; // [RQ10]
    end
    if (txActive && bitStrobe && ackSlot && busSync2) begin
      next_event[`BIT_ACK_ERR] = 1'b1; // [RQ11]
    end
  end

  // ----------------------------------------
  // per-object flags and control, set beats clear
  // ----------------------------------------
  integer k;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pageObj <= `ZERO_NIBBLE;
      for (k = 0; k < `OBJ_COUNT; k = k + 1) begin
        flags[k] <= `ZERO_BYTE;
        ctrl[k] <= `ZERO_BYTE;
      end
    end else begin
      if (sfrWr && sfrAddr == `ADDR_PAGE && sfrWdata[7:4] <= `OBJ_LAST) begin
        pageObj <= sfrWdata[7:4]; // [RQ19]
      end
      for (k = 0; k < `OBJ_COUNT; k = k + 1) begin
        // software clears by writing zero to a flag bit
        if (sfrWr && sfrAddr == `ADDR_OBJECT_STATUS && pageObj == k) begin
          flags[k] <= (flags[k] & sfrWdata) | (eventObj == k ? next_event :
            `ZERO_BYTE); // [RQ12]
        end else if (eventObj == k) begin
          flags[k] <= flags[k] | next_event; // [RQ12]
        end
        if (txDone && servedTx == k) begin
          flags[k][`BIT_TX_DONE] <= 1'b1; // [RQ2]
          ctrl[k][7:6] <= 2'h0;
        end
        if (rxDone && rxWinner == k) begin
          flags[k][`BIT_RX_DONE] <= 1'b1; // [RQ4]
          if (rxLength != ctrl[k][3:0]) begin
            flags[k][`BIT_LENGTH_WARN] <= 1'b1; // [RQ1]
          end
          ctrl[k][3:0] <= rxLength;
          if (ctrl[k][7:6] == `CTRL_CONF_RX) begin
            ctrl[k][7:6] <= 2'h0;
          end
        end
        if (sfrWr && sfrAddr == `ADDR_OBJECT_CONTROL && pageObj == k) begin
          ctrl[k] <= sfrWdata;
        end
      end
    end
  end

  // ----------------------------------------
  // identifier tags, held unreset in small memories
  // ----------------------------------------
  obj_memory tagOne (
    .core_clk(core_clk),
    .writeEn(sfrWr && sfrAddr == `ADDR_ID_TAG_ONE),
    .writeAddr(pageObj),
    .writeData(sfrWdata),
    .readAddr(pageObj),
    .readData(tagOneData)
  ); // [RQ13] [RQ17]

  obj_memory tagTwo (
    .core_clk(core_clk),
    .writeEn(sfrWr && sfrAddr == `ADDR_ID_TAG_TWO),
    .writeAddr(pageObj),
    .writeData({sfrWdata[7:5], 5'h00}),
    .readAddr(pageObj),
    .readData(tagTwoData)
  ); // [RQ14] [RQ16]

  // ----------------------------------------
  // read mux and interrupt
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sfrRdata <= `ZERO_BYTE;
      canIrq <= 1'b0;
    end else begin
      canIrq <= |anyFlag; // [RQ12]
      case (sfrAddr)
        `ADDR_PAGE: sfrRdata <= {pageObj, `ZERO_NIBBLE};
        `ADDR_OBJECT_STATUS: sfrRdata <= flags[pageObj]; // [RQ19]
        `ADDR_OBJECT_CONTROL: sfrRdata <= ctrl[pageObj];
        // tags read one cycle late through the memory register
        `ADDR_ID_TAG_ONE: sfrRdata <= ctrl[pageObj][`CTRL_EXT_BIT] ? `ZERO_BYTE :
          tagOneData; // [RQ18]
        `ADDR_ID_TAG_TWO: sfrRdata <= tagTwoData;
        `ADDR_ID_TAG_THREE: sfrRdata <= `ZERO_BYTE; // [RQ15]
        default: sfrRdata <= `ZERO_BYTE;
      endcase
    end
  end
endmodule // can_obj_status
`default_nettype wire

// File: verification/can_obj_status_asserts.sv
// checker for the object status block
`timescale 1ns/10ps
`default_nettype none
module can_obj_status_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sfrWr,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrRdata,
  input wire logic txDone,
  input wire logic rxDone,
  input wire logic [14:0] rxHit,
  input wire logic canIrq,
  input wire logic [3:0] txObject,
  input wire logic txStart,
  input wire logic [3:0] rxObject
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // object 14 never wins
  function automatic logic [3:0] low(input logic [14:0] h);
    low = 4'hf;
    for (int i = 13; i >= 0; i--)
      if (h[i]) low = i[3:0];
  endfunction
  sequence s_rx;
    rxDone && rxHit[13:0] != 14'h0000;
  endsequence
  sequence s_tag3;
    (sfrAddr == 8'hbe) [*2];
  endsequence
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |=> txObject == 4'hf &&
    rxObject == 4'hf && !canIrq && !txStart) else $error("bad reset outputs");
  a_rx_lowest: assert property (s_rx |=> rxObject == low($past(rxHit)))
    else $error("rx object not lowest hit");
  a_rx_irq: assert property (s_rx |-> ##[1:2] canIrq)
    else $error("no irq after reception");
  a_tx_irq: assert property (txDone && txObject != 4'hf |-> ##[1:2] canIrq)
    else $error("no irq after transmission");
  a_irq_hold: assert property (canIrq && !sfrWr && !$past(sfrWr) |=> canIrq)
    else $error("irq dropped without a write");
  a_start_pulse: assert property (txStart |=> !txStart)
    else $error("tx start longer than a cycle");
  a_obj_range: assert property (txObject != 4'he && rxObject != 4'he)
    else $error("object 14 served");
  a_tag3_zero: assert property (s_tag3 |=> sfrRdata == 8'h00)
    else $error("tag byte three not zero");
  a_unmapped_zero: assert property ((sfrAddr == 8'h00) [*2] |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // can_obj_status_asserts
bind can_obj_status can_obj_status_asserts i_chk (.core_clk, .rst_n, .sfrWr, .sfrAddr,
  .sfrRdata, .txDone, .rxDone, .rxHit, .canIrq, .txObject, .txStart, .rxObject);
`default_nettype wire

// File: verification/can_bus_node.sv
// other nodes on the bus, seen as the level read back
`timescale 1ns/10ps
`default_nettype none
module can_bus_node (
  input wire logic txActive,
  input wire logic txLevel,
  input wire logic ackSlot,
  input wire logic ackOn,
  input wire logic corrupt,
  output logic busLevelPin
);
  // idle bus floats recessive; corrupt fakes a disturbed bit
  assign busLevelPin = !txActive ? 1'b1 : (ackSlot && ackOn) ? 1'b0 : txLevel ^ corrupt;
endmodule // can_bus_node
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the object status block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = '0, rst_n = '0, sfrWr = '0, sfrRd = '0, busReady = '0, txDone = '0;
  logic rxDone = '0, txActive = '0, txLevel = '1, inArbOrAck = '0, bitStrobe = '0;
  logic stuffedField = '0, crcMismatch = '0, fixedFieldBad = '0, ackSlot = '0;
  logic ackOn = '1, corrupt = '0, inErrorFrame = '0;
  logic [7:0] sfrAddr = '0, sfrWdata = '0, rdv;
  logic [14:0] rxHit = '0;
  logic [3:0] rxLength = '0;
  wire busLevelPin, canIrq, txStart;
  wire [7:0] sfrRdata;
  wire [3:0] txObject, rxObject;
  int n_errors = 0, tests_run = 0;
  always #4 core_clk = ~core_clk;
  can_obj_status i_dut (.core_clk, .rst_n, .sfrWr, .sfrRd, .sfrAddr, .sfrWdata, .sfrRdata,
    .busReady, .txDone, .rxDone, .rxHit, .rxLength, .txActive, .txLevel, .busLevelPin,
    .inArbOrAck, .inErrorFrame, .bitStrobe, .stuffedField, .crcMismatch,
    .fixedFieldBad, .ackSlot, .canIrq, .txObject, .txStart, .rxObject);
  can_bus_node i_node (.txActive, .txLevel, .ackSlot, .ackOn, .corrupt, .busLevelPin);
  // ----
  // helpers
  // ----
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    tick(1);
    sfrWr = 1'b0;
  endtask
  // tag bytes answer two edges late, so wait three
  task automatic rd(input logic [7:0] a);
    tick(1);
    sfrAddr = a;
    sfrRd = 1'b1;
    tick(3);
    rdv = sfrRdata;
    sfrRd = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // leaves time for the two-flop bus synchroniser
  task automatic strobe(input int n);
    tick(3);
    bitStrobe = 1'b1;
    tick(n);
    bitStrobe = 1'b0;
  endtask
  task automatic st(input logic [3:0] obj, input logic [7:0] exp);
    wr(8'hb1, {obj, 4'h0});
    rd(8'hb2);
    check(rdv, exp);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_tags;
    wr(8'hb1, 8'h20);
    wr(8'hbc, 8'ha5);
    wr(8'hbd, 8'h60);
    rd(8'hbc);
    check(rdv, 8'ha5);
    rd(8'hbd);
    check(rdv & 8'he0, 8'h60);
    rd(8'hbe);
    check(rdv, 8'h00);
    rd(8'h00);
    check(rdv, 8'h00);
  endtask
  task automatic t_tx;
    wr(8'hb1, 8'h30);
    wr(8'hb3, 8'h40);
    wr(8'hb1, 8'h10);
    wr(8'hb3, 8'h40);
    pulse(busReady);
    check({7'h00, txStart}, 8'h01);
    tick(1);
    check({4'h0, txObject}, 8'h01);
    txActive = 1'b1;
    corrupt = 1'b1;
    inArbOrAck = 1'b1;
    strobe(4);
    st(4'h1, 8'h00);
    inArbOrAck = 1'b0;
    inErrorFrame = 1'b1;
    strobe(4);
    st(4'h1, 8'h00);
    inErrorFrame = 1'b0;
    strobe(4);
    st(4'h1, 8'h10);
    corrupt = 1'b0;
    ackOn = 1'b0;
    ackSlot = 1'b1;
    strobe(1);
    ackSlot = 1'b0;
    pulse(fixedFieldBad);
    pulse(txDone);
    st(4'h1, 8'h53);
    txActive = 1'b0;
  endtask
  task automatic t_rx;
    wr(8'hb1, 8'h40);
    wr(8'hb3, 8'h82);
    wr(8'hb1, 8'h60);
    wr(8'hb3, 8'h82);
    rxHit = 15'h0050;
    rxLength = 4'h3;
    crcMismatch = 1'b1;
    pulse(rxDone);
    crcMismatch = 1'b0;
    tick(1);
    check({4'h0, rxObject}, 8'h04);
    stuffedField = 1'b1;
    strobe(7);
    stuffedField = 1'b0;
    st(4'h4, 8'hac);
  endtask
  task automatic t_clear;
    check({7'h00, canIrq}, 8'h01);
    wr(8'hb2, 8'h00);
    st(4'h4, 8'h00);
    st(4'h1, 8'h53);
    wr(8'hb2, 8'hfe);
    st(4'h1, 8'h52);
    wr(8'hb2, 8'h00);
    tick(3);
    check({7'h00, canIrq}, 8'h00);
  endtask
  initial begin
    tick(6);
    rst_n = 1'b1;
    check({4'h0, txObject}, 8'h0f);
    t_tags;
    t_tx;
    t_rx;
    t_clear;
    close_out;
  end
  initial begin
    #200000;
    n_errors++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
